/* File: pcirp_map.vh */
// constants for the bridge read prefetch policy block
`ifndef PCIRP_MAP_VH
`define PCIRP_MAP_VH

// pci bus command codes for the read commands
`define PCIRP_CMD_IORD 4'h2
`define PCIRP_CMD_MEMRD 4'h6
`define PCIRP_CMD_CFGRD 4'ha
`define PCIRP_CMD_MRM 4'hc
`define PCIRP_CMD_MRL 4'he

// byte enables are active low on the bus
`define PCIRP_BE_ALL_ON 4'h0

// boundary masks over the low dword address bits
`define PCIRP_MASK_W 10
`define PCIRP_MASK_ONE 10'h000
`define PCIRP_MASK_16DW 10'h00f
`define PCIRP_MASK_32DW 10'h01f
`define PCIRP_MASK_4KB 10'h3ff

// line size settings that name a usable cache line
`define PCIRP_LS_1 8'h01
`define PCIRP_LS_2 8'h02
`define PCIRP_LS_4 8'h04
`define PCIRP_LS_8 8'h08
`define PCIRP_LS_16 8'h10

// read data buffer shape
`define PCIRP_FIFO_W 32
`define PCIRP_FIFO_D 16
`define PCIRP_FIFO_AW 4

// controller states
`define PCIRP_ST_IDLE 2'h0
`define PCIRP_ST_FETCH 2'h1
`define PCIRP_ST_DRAIN 2'h2

`endif

/* File: pcirp_fifo.v */
// read data buffer between target side and initiator side
`timescale 1ns/1ps
module pcirp_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire flush_i,
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output wire in_ready_o,
	output wire out_valid_o,
	output wire [WIDTH-1:0] out_data_o,
	input wire out_ready_i,
	output wire [AW:0] count_o
);
	// full level at the counter's width
	localparam [AW:0] FULL_LVL = DEPTH;

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage words
	reg [AW-1:0] wr_ptr_reg; // next write slot
	reg [AW-1:0] rd_ptr_reg; // oldest word
	reg [AW:0] cnt_reg; // words held
	wire push; // word accepted
	wire pop; // word handed out

	// flush drops everything, including a same-cycle push
	assign push = in_valid_i & in_ready_o & ~flush_i;
	assign pop = out_valid_o & out_ready_i & ~flush_i;
	assign in_ready_o = (cnt_reg != FULL_LVL);
	assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign count_o = cnt_reg;

	// storage write, no reset needed on data
	always @(posedge sys_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers and fill count
	always @(posedge sys_clk_i) begin
		if (!rst_n_i || flush_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

/* File: pcirp_policy.v */
// read forwarding and prefetch policy of a two-port bridge
`timescale 1ns/1ps
`include "pcirp_map.vh"
module pcirp_policy (
	input wire sys_clk_i,
	input wire rst_n_i,
	// captured delayed read request
	input wire req_valid_i,
	input wire [3:0] req_cmd_i,
	input wire [31:0] req_addr_i,
	input wire [3:0] req_be_n_i,
	input wire req_downstream_i,
	output wire req_ready_o,
	// policy settings
	input wire [31:0] pf_base_i,
	input wire [31:0] pf_limit_i,
	input wire up_prefetch_en_i,
	input wire [7:0] line_size_setting_i,
	input wire flow_en_i,
	// target bus side
	output reg tgt_start_o,
	output reg [31:0] tgt_addr_o,
	output reg [3:0] tgt_cmd_o,
	output reg [3:0] tgt_be_n_o,
	output reg tgt_prefetch_o,
	output wire tgt_active_o,
	output wire tgt_last_o,
	output wire tgt_ready_o,
	input wire tgt_data_valid_i,
	input wire [31:0] tgt_data_i,
	input wire tgt_disc_i,
	// initiator bus side
	output wire ini_valid_o,
	output wire [31:0] ini_data_o,
	output wire ini_disc_o,
	input wire ini_take_i,
	input wire ini_end_i,
	output reg flow_o
);
	reg [1:0] state_reg; // controller state
	reg [1:0] state_next;
	reg [29:0] cur_dw_reg; // dword address being fetched
	reg [29:0] cur_dw_next;
	reg [9:0] mask_reg; // boundary mask in force
	reg [9:0] mask_next;
	reg flow_next;
	reg start_next;
	reg flush; // drop buffered data this cycle
	reg pf_class; // request is prefetchable
	reg [9:0] mask_calc; // boundary mask for the request
	wire in_window; // address inside prefetch window
	wire ls_valid; // line size names a usable line
	wire [7:0] ls_m1; // line size minus one
	wire fifo_in_ready; // buffer has a free word
	wire fifo_out_valid; // buffer holds a word
	wire [4:0] fifo_cnt; // words in buffer
	wire push; // target dword accepted
	wire pop; // initiator dword taken
	wire at_bound; // current dword ends the fetch
	wire early_drain; // initiator may take during fetch

	// request window and line size decode
	// the window is inclusive at both ends and compares the full byte
	// address, so a window that ends mid-dword still behaves sensibly
	// line sizes other than a power of two up to sixteen are treated as
	// unusable and fall back to the fixed sixteen or thirty-two dword
	// boundaries below
	assign in_window = (req_addr_i >= pf_base_i) &&
		(req_addr_i <= pf_limit_i);
	assign ls_valid = (line_size_setting_i == `PCIRP_LS_1) ||
		(line_size_setting_i == `PCIRP_LS_2) ||
		(line_size_setting_i == `PCIRP_LS_4) ||
		(line_size_setting_i == `PCIRP_LS_8) ||
		(line_size_setting_i == `PCIRP_LS_16);
	assign ls_m1 = line_size_setting_i - 8'h01;

	// classify the request before it goes out
	// line and multiple reads always prefetch, whatever the address
	// plain memory reads depend on direction: downstream uses the window,
	// upstream follows the programmable enable
	// io, config and any unknown code stay single dword, since reads of
	// those spaces may have side effects in the target
	always @* begin
		pf_class = 1'b0;
		case (req_cmd_i)
			`PCIRP_CMD_MRL: begin
				pf_class = 1'b1;
			end
			`PCIRP_CMD_MRM: begin
				pf_class = 1'b1;
			end
			`PCIRP_CMD_MEMRD: begin
				if (req_downstream_i) begin
					pf_class = in_window;
				end else begin
					pf_class = up_prefetch_en_i;
				end
			end
			default: begin
				pf_class = 1'b0; // io and config reads
			end
		endcase
	end

	// boundary size for non-flow-through prefetch
	// the mask holds the low dword address bits of one aligned block;
	// the fetch ends on the dword whose masked bits are all ones
	// a zero mask means every dword is the last, giving one dword reads
	// twice the line size is the line mask shifted up with a one filled in
	// flow-through later widens the mask to a whole 4KB page
	always @* begin
		mask_calc = `PCIRP_MASK_ONE;
		if (!pf_class) begin
			mask_calc = `PCIRP_MASK_ONE; // single dword
		end else if (req_cmd_i == `PCIRP_CMD_MRM) begin
			if (ls_valid) begin
				mask_calc = {1'b0, ls_m1, 1'b1}; // twice line
			end else begin
				mask_calc = `PCIRP_MASK_32DW;
			end
		end else begin
			if (ls_valid) begin
				mask_calc = {2'b00, ls_m1}; // line boundary
			end else begin
				mask_calc = `PCIRP_MASK_16DW;
			end
		end
	end

	// last dword before the aligned boundary
	assign at_bound = ((cur_dw_reg[9:0] & mask_reg) == mask_reg);

	// target side handshakes
	// ready drops as soon as the buffer is full, which holds the target
	// in wait states instead of losing a dword
	// last is only a hint to the target side sequencer; the fetch itself
	// ends on the accepted dword that meets the boundary
	assign tgt_active_o = (state_reg == `PCIRP_ST_FETCH);
	assign tgt_last_o = tgt_active_o & at_bound;
	// buffer space throttles the fetch
	assign tgt_ready_o = tgt_active_o & fifo_in_ready;
	assign push = tgt_data_valid_i & tgt_ready_o;
	assign req_ready_o = (state_reg == `PCIRP_ST_IDLE);

	// a repeating initiator may drain while the fetch runs
	// only prefetchable reads with flow-through allowed may drain early;
	// single dword reads always wait for the drain state
	// the disconnect flag follows the buffer count, so it is valid in
	// both the fetch and the drain state
	assign early_drain = tgt_active_o & tgt_prefetch_o & flow_en_i;
	assign ini_valid_o = fifo_out_valid &
		((state_reg == `PCIRP_ST_DRAIN) | early_drain);
	assign pop = ini_valid_o & ini_take_i;
	// disconnect goes with the last buffered dword
	assign ini_disc_o = ini_valid_o & (fifo_cnt == 5'h01);

	// next state and fetch progress
	// idle: take one request and latch its boundary mask
	// fetch: accept target dwords until boundary, target disconnect, or
	//   the initiator ends the transfer; an early take before the
	//   boundary switches to flow-through
	// drain: hand out what is buffered, disconnecting with the last word
	// an initiator end or a disconnect take always flushes the buffer,
	// so no stale dwords can leak into the next read
	// a cut fetch with nothing buffered simply returns to idle
	// hazard: in flow-through an empty buffer also disconnects, so a slow
	//   target can end a long burst early; the initiator may repeat
	always @* begin
		state_next = state_reg;
		cur_dw_next = cur_dw_reg;
		mask_next = mask_reg;
		flow_next = flow_o;
		start_next = 1'b0;
		flush = 1'b0;
		case (state_reg)
			`PCIRP_ST_IDLE: begin
				flow_next = 1'b0;
				if (req_valid_i) begin
					// issue the delayed read on the target bus
					start_next = 1'b1;
					cur_dw_next = req_addr_i[31:2];
					mask_next = mask_calc;
					state_next = `PCIRP_ST_FETCH;
				end
			end
			`PCIRP_ST_FETCH: begin
				if (push) begin
					cur_dw_next = cur_dw_reg + 30'h00000001;
				end
				if (ini_end_i || (pop && ini_disc_o)) begin
					// initiator finished, drop the rest
					flush = 1'b1;
					flow_next = 1'b0;
					state_next = `PCIRP_ST_IDLE;
				end else if ((push && at_bound) || tgt_disc_i) begin
					// boundary or target disconnect ends fetch
					state_next = `PCIRP_ST_DRAIN;
				end else if (pop && !flow_o) begin
					// draining before the boundary
					flow_next = 1'b1;
					mask_next = `PCIRP_MASK_4KB;
				end
			end
			`PCIRP_ST_DRAIN: begin
				if (ini_end_i || (pop && ini_disc_o)) begin
					// leftover data is never kept
					flush = 1'b1;
					flow_next = 1'b0;
					state_next = `PCIRP_ST_IDLE;
				end else if (!fifo_out_valid) begin
					// fetch ended with nothing buffered
					flow_next = 1'b0;
					state_next = `PCIRP_ST_IDLE;
				end
			end
			default: begin
				flush = 1'b1;
				state_next = `PCIRP_ST_IDLE;
			end
		endcase
	end

	// controller registers
	// reset is synchronous; all state returns to idle with an empty buffer
	// the start pulse lasts exactly one cycle after the request is taken
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= `PCIRP_ST_IDLE;
			cur_dw_reg <= 30'h00000000;
			mask_reg <= `PCIRP_MASK_ONE;
			flow_o <= 1'b0;
			tgt_start_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			cur_dw_reg <= cur_dw_next;
			mask_reg <= mask_next;
			flow_o <= flow_next;
			tgt_start_o <= start_next;
		end
	end

	// captured command, address and byte enables for the target
	// these hold until the next request is taken, so the target side can
	// repeat the read after a retry without asking again
	// prefetching forces every lane on, since byte enables of later data
	// phases are unknown
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			tgt_addr_o <= 32'h00000000;
			tgt_cmd_o <= 4'h0;
			tgt_be_n_o <= 4'hf;
			tgt_prefetch_o <= 1'b0;
		end else if (req_valid_i && req_ready_o) begin
			tgt_addr_o <= req_addr_i;
			tgt_cmd_o <= req_cmd_i;
			tgt_prefetch_o <= pf_class;
			if (pf_class) begin
				tgt_be_n_o <= `PCIRP_BE_ALL_ON;
			end else begin
				tgt_be_n_o <= req_be_n_i;
			end
		end
	end

	// read data buffer between the two buses
	// sixteen words deep; its fill count drives both the fetch throttle
	// and the disconnect with the final word
	// a flush empties it in one cycle and also drops a same-cycle push
	// depth limits a non-flow-through fetch, so the largest boundary
	// that fits without stalling is sixteen dwords
	// longer boundaries rely on the initiator draining in flow-through
	// or on the target disconnecting while the buffer is full
	pcirp_fifo #(
		.WIDTH(`PCIRP_FIFO_W),
		.DEPTH(`PCIRP_FIFO_D),
		.AW(`PCIRP_FIFO_AW)
	) u_rdbuf (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(flush),
		.in_valid_i(push),
		.in_data_i(tgt_data_i),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(ini_data_o),
		.out_ready_i(pop),
		.count_o(fifo_cnt)
	);
endmodule

/* File: pcirp_policy_monitor.sv */
// checker of the read prefetch policy at the policy block ports
`timescale 1ns/1ps
module pcirp_policy_mon (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire req_valid_i,
	input wire req_ready_o,
	input wire tgt_start_o,
	input wire [3:0] tgt_cmd_o,
	input wire [3:0] tgt_be_n_o,
	input wire tgt_prefetch_o,
	input wire tgt_active_o,
	input wire tgt_last_o,
	input wire tgt_ready_o,
	input wire tgt_data_valid_i,
	input wire tgt_disc_i,
	input wire ini_valid_o,
	input wire ini_disc_o,
	input wire ini_take_i,
	input wire ini_end_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// request taken, then a single start pulse while fetching
	sequence s_take;
		req_valid_i && req_ready_o;
	endsequence
	sequence s_issue;
		tgt_start_o && tgt_active_o ##1 !tgt_start_o;
	endsequence
	a_start_once: assert property (s_take |=> s_issue)
		else $error("start pulse missing after request");
	a_busy_refuse: assert property (tgt_active_o |-> !req_ready_o)
		else $error("request accepted during fetch");
	a_pf_be_on: assert property (tgt_start_o && tgt_prefetch_o |->
		tgt_be_n_o == 4'h0) else $error("prefetch byte enables");
	a_io_no_pf: assert property (tgt_start_o && (tgt_cmd_o == 4'h2 ||
		tgt_cmd_o == 4'ha) |-> !tgt_prefetch_o)
		else $error("io or config read prefetched");
	a_line_mult_pf: assert property (tgt_start_o && tgt_cmd_o[3:2] == 2'b11
		|-> tgt_prefetch_o) else $error("line read not prefetched");
	a_nonpf_single: assert property (tgt_active_o && !tgt_prefetch_o |->
		tgt_last_o) else $error("non-prefetch fetch over one dword");
	a_fetch_stop: assert property (tgt_data_valid_i && tgt_ready_o &&
		(tgt_last_o || tgt_disc_i) |=> !tgt_active_o)
		else $error("fetch continues past its end");
	a_ready_fetch: assert property (tgt_ready_o |-> tgt_active_o)
		else $error("target ready outside fetch");
	a_nonpf_disc: assert property (ini_valid_o && !tgt_prefetch_o |->
		ini_disc_o) else $error("single dword without disconnect");
	a_take_flush: assert property (ini_valid_o && ini_take_i && ini_disc_o
		|=> !ini_valid_o) else $error("data after disconnect");
	a_end_flush: assert property (ini_end_i |=> !ini_valid_o)
		else $error("leftover data kept after end");
endmodule
bind pcirp_policy pcirp_policy_mon pcirp_policy_mon_i (.*);

/* File: pcirp_tgt_model.sv */
// target bus model answering each fetched dword with its own address
`timescale 1ns/1ps
module pcirp_tgt_model (
	input wire sys_clk_i,
	input wire start_i,
	input wire [31:0] addr_i,
	input wire ready_i,
	input wire active_i,
	input wire stall_i,
	input wire [4:0] disc_after_i,
	output reg valid_o,
	output reg [31:0] data_o,
	output wire disc_o
);
	reg [31:0] next_reg = 0; // address of the dword on offer
	reg [4:0] cnt_reg = 0; // dwords handed over so far
	reg rdy = 0;
	// disconnect with the chosen dword, zero means never
	assign disc_o = valid_o && disc_after_i != 0 &&
		cnt_reg + 5'h1 == disc_after_i;
	initial begin
		valid_o = 0;
		data_o = 0;
	end
	// advance on acceptance, offer after the edge
	always @(posedge sys_clk_i) begin
		rdy = ready_i;
		if (start_i) begin
			next_reg <= {addr_i[31:2], 2'b00};
			cnt_reg <= 0;
		end else if (valid_o && rdy) begin
			next_reg <= next_reg + 32'h4;
			cnt_reg <= cnt_reg + 5'h1;
		end
		#2;
		// a refused dword is held until taken
		if (!(valid_o && !rdy && active_i)) begin
			valid_o = active_i && !start_i && !stall_i;
			data_o = valid_o ? next_reg : ~data_o; // idle bus never stale
		end
	end
endmodule

/* File: tb_top.sv */
// testbench of the read prefetch policy block
`timescale 1ns/1ps
module tb_top;
	reg sys_clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_downstream_i = 0;
	reg [3:0] req_cmd_i = 0, req_be_n_i = 4'hf;
	reg [31:0] req_addr_i = 0, pf_base_i = 32'h1000_0000;
	reg [31:0] pf_limit_i = 32'h1fff_ffff;
	reg up_prefetch_en_i = 0, flow_en_i = 0, ini_take_i = 0, ini_end_i = 0;
	reg [7:0] line_size_setting_i = 0;
	wire req_ready_o, tgt_start_o, tgt_prefetch_o, tgt_active_o, tgt_last_o;
	wire tgt_ready_o, tgt_data_valid_i, tgt_disc_i, ini_valid_o;
	wire ini_disc_o, flow_o;
	wire [31:0] tgt_addr_o, tgt_data_i, ini_data_o;
	wire [3:0] tgt_cmd_o, tgt_be_n_o;
	reg stall = 0, fl = 0, ended = 0, flow_seen = 0;
	reg [4:0] disc_after = 0;
	integer seed = 32'hb9fcb2b3, error_cnt = 0, n_compared = 0;
	integer lim = 0, taken = 0;
	reg [31:0] r;
	reg [32:0] expq[$]; // disconnect flag and dword per expected word
	pcirp_policy pcirp_policy_i (.*);
	pcirp_tgt_model pcirp_tgt_model_i (.sys_clk_i(sys_clk_i),
		.start_i(tgt_start_o), .addr_i(tgt_addr_o), .ready_i(tgt_ready_o),
		.active_i(tgt_active_o), .stall_i(stall), .disc_after_i(disc_after),
		.valid_o(tgt_data_valid_i), .data_o(tgt_data_i), .disc_o(tgt_disc_i));
	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	task chk(input [32:0] seen, input [32:0] exp, input string what);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task summarize;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// random stalls of both sides outside flow-through runs, initiator take and end
	always @(posedge sys_clk_i) begin
		#2;
		r = $random(seed);
		stall = r[1] && !fl;
		ini_end_i = lim != 0 && taken == lim && !ended;
		if (ini_end_i)
			ended = 1;
		ini_take_i = ini_valid_o && (fl || !r[0]) && !ini_end_i &&
			(lim == 0 || taken < lim) &&
			(!tgt_active_o || (fl && !ini_disc_o));
	end
	// each word taken is matched with the oldest note
	always @(posedge sys_clk_i) begin
		if (flow_o === 1'b1)
			flow_seen = 1;
		if (ini_valid_o === 1'b1 && ini_take_i) begin
			taken = taken + 1;
			chk({ini_disc_o, ini_data_o}, expq.size() ? expq.pop_front() :
				33'h1_dead_beef, "initiator word");
		end
	end
	// one read: note expected words, issue, check target fields
	task run(input [3:0] c, input [31:0] a, input [3:0] b, input d, u,
		input [7:0] ls, input [4:0] dc, input integer lm, input f);
		reg pf, v;
		reg [9:0] m;
		integer n, k;
		begin
			pf = c == 4'hc || c == 4'he || (c == 4'h6 &&
				(d ? a >= pf_base_i && a <= pf_limit_i : u));
			v = ls == 1 || ls == 2 || ls == 4 || ls == 8 || ls == 16;
			m = !pf ? 0 : f ? 10'h3ff : c == 4'hc ? (v ? 2 * ls - 1 : 31) :
				(v ? ls - 1 : 15);
			n = m - (a[11:2] & m) + 1;
			if (dc != 0 && dc < n)
				n = dc;
			for (k = 0; k < n && (lm == 0 || k < lm); k++)
				expq.push_back({k == n - 1, a + 4 * k});
			@(posedge sys_clk_i);
			#2;
			lim = lm;
			taken = 0;
			ended = 0;
			fl = f;
			disc_after = dc;
			{req_valid_i, req_cmd_i, req_addr_i, req_be_n_i} = {1'b1, c, a, b};
			{req_downstream_i, up_prefetch_en_i, flow_en_i} = {d, u, f};
			line_size_setting_i = ls;
			@(posedge sys_clk_i);
			#2 req_valid_i = 0;
			chk(tgt_start_o, 1, "start");
			chk(tgt_prefetch_o, pf, "prefetch");
			chk(tgt_be_n_o, pf ? 4'h0 : b, "byte enables");
			chk({tgt_cmd_o, tgt_addr_o}, {c, a}, "command");
			k = 0;
			while (k < 400 && !(req_ready_o === 1'b1 && expq.size() == 0)) begin
				@(posedge sys_clk_i);
				k = k + 1;
			end
			chk(k < 400, 1, "completion");
		end
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_i);
		#2 rst_n_i = 1;
		run(4'h2, 32'h1000_0010, 4'h5, 1, 0, 8'h08, 0, 0, 0);
		run(4'ha, 32'h0000_0104, 4'ha, 0, 1, 8'h08, 0, 0, 0);
		run(4'h6, 32'h1000_000c, 4'h3, 1, 0, 8'h08, 0, 0, 0);
		run(4'h6, 32'h2000_000c, 4'h3, 1, 1, 8'h08, 0, 0, 0);
		run(4'h6, 32'h0000_0020, 4'h1, 0, 1, 8'h00, 0, 0, 0);
		run(4'h6, 32'h0000_0020, 4'h1, 0, 0, 8'h00, 0, 0, 0);
		run(4'he, 32'h3000_0008, 4'h7, 0, 0, 8'h04, 0, 0, 0);
		run(4'he, 32'h3000_0000, 4'h0, 0, 0, 8'h10, 0, 0, 0);
		run(4'hc, 32'h3000_0004, 4'h0, 0, 0, 8'h02, 0, 0, 0);
		run(4'hc, 32'h3000_0024, 4'h0, 0, 0, 8'h08, 0, 0, 0);
		run(4'hc, 32'h3000_0050, 4'h0, 0, 0, 8'h00, 0, 0, 0);
		run(4'he, 32'h3000_0000, 4'h0, 0, 0, 8'h08, 3, 0, 0);
		run(4'hc, 32'h3000_0000, 4'h0, 0, 0, 8'h04, 0, 2, 0);
		run(4'he, 32'h3000_0fc0, 4'h0, 0, 0, 8'h04, 0, 0, 1);
		chk(flow_seen, 1, "flow entered");
		summarize;
	end
	initial begin
		#(25 * 20000);
		error_cnt = error_cnt + 1;
		summarize;
	end
endmodule
